// >>> rtl/pdac_pkg.sv
package pdac_pkg;
  // channel count and register index layout
  localparam int NUM_CHAN = 4;
  localparam int IDX_W = 3;
  localparam logic [2:0] IDX_ARB_MODE = 3'h0;
  localparam logic [2:0] IDX_ADDR_BASE = 3'h4;
  localparam logic [2:0] IDX_ADDR_LAST = 3'h7;
  localparam logic [1:0] CHAN_FIRST = 2'h0;
  localparam logic [1:0] CHAN_STEP = 2'h1;
  localparam int ARB_SEL_BIT = 0;
  localparam logic [31:0] ARB_MODE_RESET = 32'h0000_0000;
  localparam logic [31:0] ADDR_RESET = 32'h0000_0000;
  localparam logic [31:0] ADDR_ALIGN_MASK = 32'hFFFF_FFFC;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
  localparam logic [3:0] GRANT_NONE = 4'h0;

  typedef enum logic {
    PDAC_FIXED,
    PDAC_RROBIN
  } pdac_mode_t;

  typedef enum logic {
    PDAC_IDLE,
    PDAC_BUSY
  } pdac_arb_state_t;

  // one register access request from either bus side
  typedef struct packed {
    logic req;
    logic we;
    logic [IDX_W-1:0] idx;
    logic [31:0] wdata;
  } pdac_reg_req_t;

  // registered answer, one cycle after the request
  typedef struct packed {
    logic ack;
    logic err;
    logic [31:0] rdata;
  } pdac_reg_rsp_t;
endpackage

// >>> rtl/pdac_arbiter.sv
`timescale 1ns/100ps
module pdac_arbiter (
  input wire logic i_core_clk,
  input wire logic i_clear_n,
  input wire pdac_pkg::pdac_mode_t i_mode,
  input wire logic [3:0] i_chan_req,
  input wire logic i_chan_done,
  output logic o_take,
  output logic [1:0] o_pick,
  output logic [3:0] o_grant,
  output logic o_busy
);
  pdac_pkg::pdac_arb_state_t state_q, state_d;
  logic [1:0] last_q;
  logic [3:0] grant_q;
  logic [1:0] base;
  logic [1:0] cand;
  logic found;

  // search order starts at channel 0, or just after the last winner
  assign base = (i_mode == pdac_pkg::PDAC_RROBIN) ? last_q + pdac_pkg::CHAN_STEP
                                                  : pdac_pkg::CHAN_FIRST;
  always_comb begin
    found = 1'b0;
    o_pick = pdac_pkg::CHAN_FIRST;
    cand = pdac_pkg::CHAN_FIRST;
    for (int k = 0; k < pdac_pkg::NUM_CHAN; k++) begin
      cand = base + 2'(k);
      if (!found && i_chan_req[cand]) begin
        found = 1'b1;
        o_pick = cand;
      end
    end
  end

  // mode is only consulted here, so a burst in flight never sees a change
  assign o_take = (state_q == pdac_pkg::PDAC_IDLE) && found;
  assign o_busy = (state_q == pdac_pkg::PDAC_BUSY);
  assign o_grant = grant_q;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      pdac_pkg::PDAC_IDLE: if (found) state_d = pdac_pkg::PDAC_BUSY;
      pdac_pkg::PDAC_BUSY: if (i_chan_done) state_d = pdac_pkg::PDAC_IDLE;
    endcase
  end

  // winner pointer moves only on a grant
  always_ff @(posedge i_core_clk) begin
    if (!i_clear_n) begin
      state_q <= pdac_pkg::PDAC_IDLE;
      last_q <= pdac_pkg::CHAN_FIRST - pdac_pkg::CHAN_STEP;
      grant_q <= pdac_pkg::GRANT_NONE;
    end else begin
      state_q <= state_d;
      if (o_take) begin
        last_q <= o_pick;
        grant_q <= 4'(1) << o_pick;
      end else if (o_busy && i_chan_done) begin
        grant_q <= pdac_pkg::GRANT_NONE;
      end
    end
  end

  a_grant_onehot: assert property (@(posedge i_core_clk) disable iff (!i_clear_n)
    o_busy |-> $onehot(o_grant)) else $error("grant not one-hot while busy");
  a_fixed_lowest: assert property (@(posedge i_core_clk) disable iff (!i_clear_n)
    (o_take && i_mode == pdac_pkg::PDAC_FIXED && i_chan_req[0]) |-> ##1 o_grant[0])
    else $error("fixed mode did not favour channel 0");
  a_rr_rotate: assert property (@(posedge i_core_clk) disable iff (!i_clear_n)
    (o_take && i_mode == pdac_pkg::PDAC_RROBIN && &i_chan_req)
    |-> o_pick == last_q + pdac_pkg::CHAN_STEP)
    else $error("round robin did not rotate");
  a_grant_hold: assert property (@(posedge i_core_clk) disable iff (!i_clear_n)
    (o_busy && !i_chan_done) |=> (o_busy && $stable(o_grant)))
    else $error("grant changed mid burst");
endmodule

// >>> rtl/pdac_channel_ctrl.sv
`timescale 1ns/100ps
// Overview of operation
// - select bit: fixed priority or round robin
// - mode register clears on any reset
// - upper mode bits read zero, writes ignored
// - both bus sides read and write registers
// - four writable 32-bit channel start addresses
// - low two address bits dropped on use
// - address need not survive a started transfer
// - channel addresses clear on any reset
module pdac_channel_ctrl (
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire logic i_soft_reset,
  input wire pdac_pkg::pdac_reg_req_t i_pp_req,
  output pdac_pkg::pdac_reg_rsp_t o_pp_rsp,
  input wire pdac_pkg::pdac_reg_req_t i_pci_req,
  output pdac_pkg::pdac_reg_rsp_t o_pci_rsp,
  input wire logic [3:0] i_chan_req,
  input wire logic i_chan_done,
  output logic [3:0] o_chan_grant,
  output logic o_chan_start,
  output logic [31:0] o_chan_start_addr,
  output logic o_xfer_busy
);
  logic clear_n;
  logic arb_sel_q;
  logic [31:0] addr_q [pdac_pkg::NUM_CHAN];
  pdac_pkg::pdac_reg_rsp_t pp_rsp_q, pci_rsp_q;
  logic start_q;
  logic [31:0] start_addr_q;
  logic take;
  logic [1:0] pick;
  logic busy;
  pdac_pkg::pdac_mode_t mode;

  // power-on and software reset share one clear
  assign clear_n = i_reset_n && !i_soft_reset;

  // address decode, per side
  logic pp_mode_hit, pci_mode_hit, pp_addr_hit, pci_addr_hit;
  logic [1:0] pp_chan, pci_chan;
  logic pp_wr_mode, pci_wr_mode;
  assign pp_mode_hit = i_pp_req.idx == pdac_pkg::IDX_ARB_MODE;
  assign pci_mode_hit = i_pci_req.idx == pdac_pkg::IDX_ARB_MODE;
  assign pp_addr_hit = i_pp_req.idx >= pdac_pkg::IDX_ADDR_BASE;
  assign pci_addr_hit = i_pci_req.idx >= pdac_pkg::IDX_ADDR_BASE;
  assign pp_chan = i_pp_req.idx[1:0];
  assign pci_chan = i_pci_req.idx[1:0];
  assign pp_wr_mode = i_pp_req.req && i_pp_req.we && pp_mode_hit;
  assign pci_wr_mode = i_pci_req.req && i_pci_req.we && pci_mode_hit;

  // read data: reserved mode bits come back as zero
  logic [31:0] mode_word;
  logic [31:0] pp_rd, pci_rd;
  assign mode_word = {31'h0000_0000, arb_sel_q};
  assign pp_rd = pp_mode_hit ? mode_word
               : pp_addr_hit ? addr_q[pp_chan] : pdac_pkg::ZERO_WORD;
  assign pci_rd = pci_mode_hit ? mode_word
                : pci_addr_hit ? addr_q[pci_chan] : pdac_pkg::ZERO_WORD;

  assign mode = arb_sel_q ? pdac_pkg::PDAC_RROBIN : pdac_pkg::PDAC_FIXED;

  // mode bit: same-cycle writes from both sides, the internal side wins
  always_ff @(posedge i_core_clk) begin
    if (!clear_n) begin
      arb_sel_q <= pdac_pkg::ARB_MODE_RESET[pdac_pkg::ARB_SEL_BIT];
    end else if (pp_wr_mode) begin
      arb_sel_q <= i_pp_req.wdata[pdac_pkg::ARB_SEL_BIT];
    end else if (pci_wr_mode) begin
      arb_sel_q <= i_pci_req.wdata[pdac_pkg::ARB_SEL_BIT];
    end
  end

  // channel start addresses, all 32 bits stored as written
  for (genvar c = 0; c < pdac_pkg::NUM_CHAN; c++) begin : g_addr
    logic pp_wr, pci_wr;
    assign pp_wr = i_pp_req.req && i_pp_req.we && pp_addr_hit && pp_chan == 2'(c);
    assign pci_wr = i_pci_req.req && i_pci_req.we && pci_addr_hit && pci_chan == 2'(c);
    always_ff @(posedge i_core_clk) begin
      if (!clear_n) begin
        addr_q[c] <= pdac_pkg::ADDR_RESET;
      end else if (pp_wr) begin
        addr_q[c] <= i_pp_req.wdata;
      end else if (pci_wr) begin
        addr_q[c] <= i_pci_req.wdata;
      end
    end
  end

  // answers: one cycle after the request, unmapped index flags err and reads 0
  always_ff @(posedge i_core_clk) begin
    if (!clear_n) begin
      pp_rsp_q <= '0;
      pci_rsp_q <= '0;
    end else begin
      pp_rsp_q.ack <= i_pp_req.req;
      pp_rsp_q.err <= i_pp_req.req && !pp_mode_hit && !pp_addr_hit;
      pp_rsp_q.rdata <= (i_pp_req.req && !i_pp_req.we) ? pp_rd : pdac_pkg::ZERO_WORD;
      pci_rsp_q.ack <= i_pci_req.req;
      pci_rsp_q.err <= i_pci_req.req && !pci_mode_hit && !pci_addr_hit;
      pci_rsp_q.rdata <= (i_pci_req.req && !i_pci_req.we) ? pci_rd : pdac_pkg::ZERO_WORD;
    end
  end
  assign o_pp_rsp = pp_rsp_q;
  assign o_pci_rsp = pci_rsp_q;

  pdac_arbiter u_arb (
    .i_core_clk(i_core_clk),
    .i_clear_n(clear_n),
    .i_mode(mode),
    .i_chan_req(i_chan_req),
    .i_chan_done(i_chan_done),
    .o_take(take),
    .o_pick(pick),
    .o_grant(o_chan_grant),
    .o_busy(busy)
  );
  assign o_xfer_busy = busy;

  // this block copies the address into start_addr_q at start, so the register may be
  // rewritten for the next transfer while this one runs
  always_ff @(posedge i_core_clk) begin
    if (!clear_n) begin
      start_q <= 1'b0;
      start_addr_q <= pdac_pkg::ADDR_RESET;
    end else begin
      start_q <= take;
      if (take) begin
        start_addr_q <= addr_q[pick] & pdac_pkg::ADDR_ALIGN_MASK;
      end
    end
  end
  assign o_chan_start = start_q;
  assign o_chan_start_addr = start_addr_q;

  // named steps of a register write followed by a read from the other side
  sequence s_pp_addr_write;
    i_pp_req.req && i_pp_req.we && pp_addr_hit && !(i_pci_req.req && i_pci_req.we);
  endsequence
  sequence s_pci_read_same;
    i_pci_req.req && !i_pci_req.we && pci_addr_hit && pci_chan == $past(pp_chan);
  endsequence

  a_reserved_zero: assert property (@(posedge i_core_clk) disable iff (!clear_n)
    (i_pp_req.req && !i_pp_req.we && pp_mode_hit) |=> o_pp_rsp.rdata[31:1] == 31'h0000_0000)
    else $error("reserved mode bits read nonzero");
  a_cross_read: assert property (@(posedge i_core_clk) disable iff (!clear_n)
    s_pp_addr_write ##1 (s_pci_read_same and !(i_pp_req.req && i_pp_req.we))
    |=> o_pci_rsp.rdata == $past(i_pp_req.wdata, 2))
    else $error("pci side did not read pp written address");
  a_mode_cross: assert property (@(posedge i_core_clk) disable iff (!clear_n)
    (pci_wr_mode && !pp_wr_mode) |=> arb_sel_q == $past(i_pci_req.wdata[pdac_pkg::ARB_SEL_BIT]))
    else $error("pci write of select bit lost");
  a_start_align: assert property (@(posedge i_core_clk) disable iff (!clear_n)
    take |=> (o_chan_start && o_chan_start_addr[1:0] == 2'h0
              && o_chan_start_addr[31:2] == $past(addr_q[pick][31:2])))
    else $error("start address not aligned copy");
  a_soft_clear: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    i_soft_reset |=> (arb_sel_q == 1'b0 && addr_q[0] == 32'h0000_0000
                      && addr_q[3] == 32'h0000_0000 && o_chan_grant == 4'h0))
    else $error("software reset did not clear");
  a_unmapped_err: assert property (@(posedge i_core_clk) disable iff (!clear_n)
    (i_pp_req.req && !pp_mode_hit && !pp_addr_hit) |=> (o_pp_rsp.ack && o_pp_rsp.err))
    else $error("unmapped access not flagged");
  a_start_pulse: assert property (@(posedge i_core_clk) disable iff (!clear_n)
    o_chan_start |-> (o_xfer_busy && !$past(o_xfer_busy)))
    else $error("start pulse without fresh grant");
endmodule

// >>> sim/pdac_engine_model.sv
`timescale 1ns/100ps
module pdac_engine_model (
  input wire logic i_core_clk,
  input wire logic [3:0] i_want,
  input wire logic i_start,
  output logic [3:0] o_chan_req,
  output logic o_chan_done
);
  int cnt_q = 0;
  logic done_q = 1'b0;
  // requests follow what the bench wants, so the bench owns request order
  assign o_chan_req = i_want;
  assign o_chan_done = done_q;
  // fixed three-cycle burst; the model has no start address input
  always @(negedge i_core_clk) begin
    done_q <= 1'b0;
    if (i_start === 1'b1) begin
      cnt_q <= 3;
    end else if (cnt_q == 1) begin
      done_q <= 1'b1;
      cnt_q <= 0;
    end else if (cnt_q > 1) begin
      cnt_q <= cnt_q - 1;
    end
  end
endmodule

// >>> sim/pci_dma_channel_arbitration_setup_test.sv
`timescale 1ns/100ps
module pci_dma_channel_arbitration_setup_test;
  logic core_clk, reset_n, soft_reset, done, start, busy, er;
  pdac_pkg::pdac_reg_req_t pp_req, pci_req;
  pdac_pkg::pdac_reg_rsp_t pp_rsp, pci_rsp;
  logic [3:0] want, creq, grant;
  logic [31:0] saddr, rd;
  int err_total = 0;
  int tests_run = 0;

  pdac_channel_ctrl i_pdac_channel_ctrl (.i_core_clk(core_clk), .i_reset_n(reset_n),
    .i_soft_reset(soft_reset), .i_pp_req(pp_req), .o_pp_rsp(pp_rsp), .i_pci_req(pci_req),
    .o_pci_rsp(pci_rsp), .i_chan_req(creq), .i_chan_done(done), .o_chan_grant(grant),
    .o_chan_start(start), .o_chan_start_addr(saddr), .o_xfer_busy(busy));
  pdac_engine_model i_pdac_engine_model (.i_core_clk(core_clk), .i_want(want),
    .i_start(start), .o_chan_req(creq), .o_chan_done(done));

  // 8 ns period
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  function automatic logic [31:0] av(input int k);
    return 32'hC0DE_5A03 ^ (32'(k) << 12);
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one-cycle request; the answer stands in the following cycle only
  task automatic acc(input logic pci, input logic we, input logic [2:0] idx,
                     input logic [31:0] wd, output logic [31:0] rdv, output logic erv);
    pdac_pkg::pdac_reg_req_t r;
    r = '{req: 1'b1, we: we, idx: idx, wdata: wd};
    @(negedge core_clk);
    if (pci) pci_req = r;
    else pp_req = r;
    @(negedge core_clk);
    pp_req = '0;
    pci_req = '0;
    rdv = pci ? pci_rsp.rdata : pp_rsp.rdata;
    erv = pci ? pci_rsp.err : pp_rsp.err;
    chk({31'h0000_0000, (pci ? pci_rsp.ack : pp_rsp.ack)}, 32'h0000_0001);
  endtask

  task automatic wr(input logic pci, input logic [2:0] idx, input logic [31:0] wd);
    acc(pci, 1'b1, idx, wd, rd, er);
  endtask

  task automatic rdc(input logic pci, input logic [2:0] idx, input logic [31:0] exp);
    acc(pci, 1'b0, idx, 32'h0000_0000, rd, er);
    chk(rd, exp);
  endtask

  // internal side writes, the pci side reads the same register one cycle later
  task automatic wr_rd_b2b(input logic [2:0] idx, input logic [31:0] wd,
                           output logic [31:0] rdv);
    @(negedge core_clk);
    pp_req = '{req: 1'b1, we: 1'b1, idx: idx, wdata: wd};
    @(negedge core_clk);
    pp_req = '0;
    pci_req = '{req: 1'b1, we: 1'b0, idx: idx, wdata: 32'h0000_0000};
    @(negedge core_clk);
    pci_req = '0;
    rdv = pci_rsp.rdata;
  endtask

  // waits for the next start pulse, bounded so a lost grant cannot hang
  task automatic serve(input logic [3:0] exp_g, input logic [31:0] exp_a, input logic drop);
    int n;
    n = 0;
    while (start !== 1'b1 && n < 50) begin
      @(negedge core_clk);
      n++;
    end
    chk({28'h000_0000, grant}, {28'h000_0000, exp_g});
    chk(saddr, exp_a);
    chk({31'h0000_0000, busy}, 32'h0000_0001);
    if (drop) want = want & ~exp_g;
    @(negedge core_clk);
  endtask

  task automatic give_verdict;
    $display("counts: %0d compared, %0d mismatched", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // the whole sequence needs about a hundred cycles
  initial begin
    repeat (3000) @(posedge core_clk);
    err_total++;
    give_verdict();
  end

  initial begin
    reset_n = 1'b0;
    soft_reset = 1'b0;
    pp_req = '0;
    pci_req = '0;
    want = 4'h0;
    repeat (4) @(posedge core_clk);
    @(negedge core_clk);
    reset_n = 1'b1;
    rdc(1'b0, 3'h0, 32'h0000_0000);
    for (int k = 0; k < 4; k++) rdc(1'b1, 3'h4 + 3'(k), 32'h0000_0000);
    $display("test reset_values done");
    wr(1'b1, 3'h0, 32'h0000_0001);
    rdc(1'b0, 3'h0, 32'h0000_0001);
    wr(1'b0, 3'h0, 32'h0000_0000);
    rdc(1'b1, 3'h0, 32'h0000_0000);
    acc(1'b1, 1'b1, 3'h2, 32'hFFFF_FFFF, rd, er);
    chk({31'h0000_0000, er}, 32'h0000_0001);
    chk(rd, 32'h0000_0000);
    acc(1'b0, 1'b0, 3'h1, 32'h0000_0000, rd, er);
    chk({31'h0000_0000, er}, 32'h0000_0001);
    wr_rd_b2b(3'h5, 32'h1234_5678, rd);
    chk(rd, 32'h1234_5678);
    for (int k = 0; k < 4; k++) wr(1'b0, 3'h4 + 3'(k), av(k));
    for (int k = 0; k < 4; k++) rdc(1'b1, 3'h4 + 3'(k), av(k));
    $display("test register_access done");
    want = 4'hF;
    // channel 0 keeps requesting, so only fixed priority picks it twice in a row
    serve(4'h1, av(0) & 32'hFFFF_FFFC, 1'b0);
    wr(1'b0, 3'h4, av(4));
    serve(4'h1, av(4) & 32'hFFFF_FFFC, 1'b1);
    for (int k = 1; k < 4; k++) serve(4'h1 << k, av(k) & 32'hFFFF_FFFC, 1'b1);
    $display("test fixed_priority done");
    wr(1'b0, 3'h0, 32'h0000_0001);
    soft_reset = 1'b1;
    @(negedge core_clk);
    soft_reset = 1'b0;
    rdc(1'b0, 3'h0, 32'h0000_0000);
    rdc(1'b0, 3'h6, 32'h0000_0000);
    wr(1'b0, 3'h0, 32'h0000_0001);
    for (int k = 0; k < 4; k++) wr(1'b1, 3'h4 + 3'(k), av(k));
    want = 4'hF;
    for (int k = 0; k < 5; k++) serve(4'h1 << (k % 4), av(k % 4) & 32'hFFFF_FFFC, 1'b0);
    want = 4'h0;
    $display("test round_robin done");
    give_verdict();
  end
endmodule
